// File: serial_flow_control_event_tx.sv
// receive byte filter, held transmit queue and event frame builder of the serial link
//
// Summary of operation
// - stop-transmission byte halts the transmitter within fifteen further bytes
// - halted data is held up to 1023 bytes; a full queue stalls framing
// - stop-transmission byte produces no reply
// - transmission-allowed byte resumes sending and drains every held event frame
// - transmission-allowed byte produces no reply
// - command-start byte also sets the transmission-allowed state
// - after command-start every held event frame is sent
// - command-start empties the receive buffer before the new command collects
// - clear byte discards all earlier received bytes, without reply
// - every data memory change produces an unsolicited event frame
// - frame opens with start-of-text, event tag, then four hex address characters
// - two hex characters of word count follow the address
// - each word goes as four hex characters, high nibble first
// - end-of-text only with checksum on and short frame off; carriage return ends
// - with checksum on, XOR of bytes from start is sent as two hex characters
// - frame word count never exceeds a nonzero configured event word limit
// - a configured limit of zero means one word per frame
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
    } fifo_s;

    fifo_s r_reg, r_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;
    logic [AW-1:0] waddr;

    // a flush frees the whole buffer, so input is always taken with it
    assign in_ready = flush || (r_reg.cnt != FULL);
    assign out_valid = (r_reg.cnt != '0) && !flush;
    assign out_data = mem[r_reg.rd];
    assign level = r_reg.cnt;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign waddr = flush ? '0 : r_reg.wr;

    always_comb begin
        r_next = r_reg;
        if (flush) begin
            r_next.rd = '0;
            r_next.wr = push ? AW'(1) : '0;
            r_next.cnt = push ? CW'(1) : '0;
        end else begin
            if (push) begin
                r_next.wr = (r_reg.wr == LAST) ? '0 : r_reg.wr + AW'(1);
            end
            if (pop) begin
                r_next.rd = (r_reg.rd == LAST) ? '0 : r_reg.rd + AW'(1);
            end
            r_next.cnt = r_reg.cnt + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[waddr] <= in_data;
        end
    end
endmodule // byte_fifo

module serial_flow_control_event_tx
    import flow_event_pkg::*;
#(
    parameter int HOLD_MAX = flow_event_pkg::HOLD_BYTES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [flow_event_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic [7:0] cmd_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    input wire logic chg_valid,
    output logic chg_ready,
    input wire logic [15:0] chg_addr,
    input wire logic [7:0] chg_words,
    output logic [15:0] data_memory_addr,
    input wire logic [15:0] data_memory_data,
    output logic op_stall
);
    import flow_event_pkg::*;

    localparam logic [HOLD_AW-1:0] QMAX = HOLD_AW'(HOLD_MAX);
    localparam int RXLW = $clog2(RXQ_DEPTH + 1);

    typedef struct packed {
        frame_state_e st;
        logic [1:0] nib;
        logic [15:0] addr;
        logic [7:0] rem;
        logic [7:0] cnt;
        logic [7:0] widx;
        logic [15:0] word;
        logic [7:0] bcc;
        logic [15:0] rd_addr;
        logic halted;
        logic chk_on;
        logic short_on;
        logic [7:0] max_words;
        logic [HOLD_AW-1:0] q_wr;
        logic [HOLD_AW-1:0] q_rd;
        logic [HOLD_AW-1:0] q_cnt;
        logic [7:0] tx_data;
        logic tx_valid;
        logic [31:0] prdata;
        logic pslverr;
    } core_s;

    core_s r_reg, r_next;
    logic [7:0] hold_mem [2**HOLD_AW];
    logic [7:0] push_byte;
    logic push, pop, q_full, rx_take, is_ctrl;
    logic is_xoff, is_xon, is_enq, is_eot, flush;
    logic [7:0] limit, first_cnt;
    logic [RXLW-1:0] rx_level;

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        hex_char = (n < NIB_TEN) ? CHR_ZERO + 8'(n) : CHR_ALPHA + 8'(n);
    endfunction

    function automatic logic [3:0] nib_sel(input logic [15:0] v, input logic [1:0] i);
        nib_sel = v[{i, 2'b00} +: 4];
    endfunction

    // control bytes are accepted even with a full receive buffer
    assign is_xoff = rx_data == CHR_XOFF;
    assign is_xon = rx_data == CHR_XON;
    assign is_enq = rx_data == CHR_ENQ;
    assign is_eot = rx_data == CHR_EOT;
    assign is_ctrl = is_xoff || is_xon || is_eot;
    assign rx_take = rx_valid && rx_ready;
    assign flush = rx_take && (is_enq || is_eot);

    byte_fifo #(.WIDTH(8), .DEPTH(RXQ_DEPTH)) u_rxq (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .flush(flush),
        .in_valid(rx_valid && !is_ctrl),
        .in_ready(),
        .in_data(rx_data),
        .out_valid(cmd_valid),
        .out_ready(cmd_ready),
        .out_data(cmd_data),
        .level(rx_level)
    );

    // the ENQ flush always makes room, so only plain bytes see back-pressure
    assign rx_ready = is_ctrl || is_enq || (rx_level != RXLW'(RXQ_DEPTH));

    assign q_full = r_reg.q_cnt == QMAX;
    assign limit = (r_reg.max_words == 8'h00) ? 8'h01 : r_reg.max_words;
    assign first_cnt = (r_reg.rem > limit) ? limit : r_reg.rem;
    assign pop = (!r_reg.tx_valid || tx_ready) && !r_reg.halted && (r_reg.q_cnt != '0);
    assign chg_ready = r_reg.st == FR_IDLE;
    assign op_stall = (r_reg.st != FR_IDLE) && (r_reg.st != FR_FETCH) && q_full;

    always_comb begin
        push = 1'b0;
        push_byte = CHR_CR;
        unique case (r_reg.st)
            FR_IDLE: push = 1'b0;
            FR_FETCH: push = 1'b0;
            FR_STX: push_byte = CHR_STX;
            FR_TAG: push_byte = CHR_EVENT;
            FR_ADDR: push_byte = hex_char(nib_sel(r_reg.addr, r_reg.nib));
            FR_CNT: push_byte = hex_char(nib_sel({8'h00, r_reg.cnt}, r_reg.nib));
            FR_DATA: push_byte = hex_char(nib_sel(r_reg.word, r_reg.nib));
            FR_ETX: push_byte = CHR_ETX;
            FR_BCC: push_byte = hex_char(nib_sel({8'h00, r_reg.bcc}, r_reg.nib));
            FR_CR: push_byte = CHR_CR;
        endcase
        if (r_reg.st != FR_IDLE && r_reg.st != FR_FETCH) begin
            push = !q_full;
        end
    end

    always_comb begin
        r_next = r_reg;
        if (rx_take && is_xoff) begin
            r_next.halted = 1'b1;
        end else if (rx_take && (is_xon || is_enq)) begin
            r_next.halted = 1'b0;
        end

        r_next.q_cnt = r_reg.q_cnt + HOLD_AW'(push) - HOLD_AW'(pop);
        if (push) begin
            r_next.q_wr = r_reg.q_wr + HOLD_AW'(1);
        end
        if (pop) begin
            r_next.q_rd = r_reg.q_rd + HOLD_AW'(1);
            r_next.tx_data = hold_mem[r_reg.q_rd];
            r_next.tx_valid = 1'b1;
        end else if (tx_ready) begin
            r_next.tx_valid = 1'b0;
        end

        if (push) begin
            r_next.bcc = (r_reg.st == FR_STX) ? push_byte : r_reg.bcc ^ push_byte;
            if (r_reg.st == FR_BCC || r_reg.st == FR_CR) begin
                r_next.bcc = r_reg.bcc;
            end
        end

        unique case (r_reg.st)
            FR_IDLE: begin
                if (chg_valid) begin
                    r_next.addr = chg_addr;
                    r_next.rem = (chg_words == 8'h00) ? 8'h01 : chg_words;
                    r_next.st = FR_STX;
                end
            end
            FR_STX: begin
                if (push) begin
                    r_next.cnt = first_cnt;
                    r_next.widx = 8'h00;
                    r_next.st = FR_TAG;
                end
            end
            FR_TAG: begin
                if (push) begin
                    r_next.nib = 2'd3;
                    r_next.st = FR_ADDR;
                end
            end
            FR_ADDR: begin
                if (push) begin
                    r_next.nib = r_reg.nib - 2'd1;
                    if (r_reg.nib == 2'd0) begin
                        r_next.nib = 2'd1;
                        r_next.st = FR_CNT;
                    end
                end
            end
            FR_CNT: begin
                if (push) begin
                    r_next.nib = r_reg.nib - 2'd1;
                    if (r_reg.nib == 2'd0) begin
                        r_next.rd_addr = r_reg.addr;
                        r_next.st = FR_FETCH;
                    end
                end
            end
            FR_FETCH: begin
                r_next.word = data_memory_data;
                r_next.nib = 2'd3;
                r_next.st = FR_DATA;
            end
            FR_DATA: begin
                if (push) begin
                    r_next.nib = r_reg.nib - 2'd1;
                    if (r_reg.nib == 2'd0) begin
                        r_next.widx = r_reg.widx + 8'd1;
                        if (r_reg.widx + 8'd1 < r_reg.cnt) begin
                            r_next.rd_addr = r_reg.addr + 16'(r_reg.widx) + 16'd1;
                            r_next.st = FR_FETCH;
                        end else if (r_reg.chk_on && !r_reg.short_on) begin
                            r_next.st = FR_ETX;
                        end else if (r_reg.chk_on) begin
                            r_next.nib = 2'd1;
                            r_next.st = FR_BCC;
                        end else begin
                            r_next.st = FR_CR;
                        end
                    end
                end
            end
            FR_ETX: begin
                if (push) begin
                    r_next.nib = 2'd1;
                    r_next.st = FR_BCC;
                end
            end
            FR_BCC: begin
                if (push) begin
                    r_next.nib = r_reg.nib - 2'd1;
                    if (r_reg.nib == 2'd0) begin
                        r_next.st = FR_CR;
                    end
                end
            end
            FR_CR: begin
                // a change wider than the limit continues in a further frame
                if (push) begin
                    r_next.rem = r_reg.rem - r_reg.cnt;
                    r_next.addr = r_reg.addr + 16'(r_reg.cnt);
                    r_next.st = (r_reg.rem == r_reg.cnt) ? FR_IDLE : FR_STX;
                end
            end
        endcase

        // prdata and pslverr are latched in the setup cycle, ready in access
        r_next.pslverr = 1'b0;
        if (psel && !penable) begin
            r_next.prdata = '0;
            if (paddr == OFS_CTRL) begin
                r_next.prdata[CTRL_CHK_BIT] = r_reg.chk_on;
                r_next.prdata[CTRL_SHORT_BIT] = r_reg.short_on;
                r_next.prdata[CTRL_MAXW_LSB +: 8] = r_reg.max_words;
            end else if (paddr == OFS_STATUS) begin
                r_next.prdata[STAT_HALT_BIT] = r_reg.halted;
                r_next.prdata[STAT_STALL_BIT] = op_stall;
                r_next.prdata[STAT_BUSY_BIT] = r_reg.st != FR_IDLE;
                r_next.prdata[STAT_RXLVL_LSB +: RXLW] = rx_level;
                r_next.prdata[STAT_QCNT_LSB +: HOLD_AW] = r_reg.q_cnt;
            end else begin
                r_next.pslverr = 1'b1;
            end
            if (pwrite && paddr == OFS_STATUS) begin
                r_next.pslverr = 1'b1;
            end
        end else if (psel) begin
            r_next.pslverr = r_reg.pslverr;
        end
        if (psel && penable && pwrite && paddr == OFS_CTRL) begin
            r_next.chk_on = pwdata[CTRL_CHK_BIT];
            r_next.short_on = pwdata[CTRL_SHORT_BIT];
            r_next.max_words = pwdata[CTRL_MAXW_LSB +: 8];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_reg <= '0;
            r_reg.st <= FR_IDLE;
            r_reg.chk_on <= CTRL_CHK_RST;
            r_reg.short_on <= CTRL_SHORT_RST;
            r_reg.max_words <= CTRL_MAXW_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            hold_mem[r_reg.q_wr] <= push_byte;
        end
    end

    assign prdata = r_reg.prdata;
    assign pready = 1'b1;
    assign pslverr = r_reg.pslverr && psel && penable;
    assign tx_valid = r_reg.tx_valid;
    assign tx_data = r_reg.tx_data;
    assign data_memory_addr = r_reg.rd_addr;

    property p_halt_drains;
        @(posedge ref_clk) disable iff (sys_rst)
        r_reg.halted && tx_ready |=> !tx_valid;
    endproperty
    a_halt_drains: assert property (p_halt_drains) else $error("byte sent while halted");

    property p_xoff_halts;
        @(posedge ref_clk) disable iff (sys_rst)
        rx_take && is_xoff |=> r_reg.halted ##1 (r_reg.halted || $past(rx_take));
    endproperty
    a_xoff_halts: assert property (p_xoff_halts) else $error("halt not taken");

    property p_queue_cap;
        @(posedge ref_clk) disable iff (sys_rst)
        q_full && !pop |=> r_reg.q_cnt == QMAX && $stable(r_reg.q_wr);
    endproperty
    a_queue_cap: assert property (p_queue_cap) else $error("held queue overflow");

    property p_ctrl_silent;
        @(posedge ref_clk) disable iff (sys_rst)
        rx_take && (is_xoff || is_xon) && r_reg.st == FR_IDLE && !chg_valid
            |=> r_reg.q_cnt <= $past(r_reg.q_cnt) && rx_level <= $past(rx_level);
    endproperty
    a_ctrl_silent: assert property (p_ctrl_silent) else $error("reply to flow byte");

    property p_xon_resume;
        @(posedge ref_clk) disable iff (sys_rst)
        rx_take && (is_xon || is_enq) |=> !r_reg.halted;
    endproperty
    a_xon_resume: assert property (p_xon_resume) else $error("resume not taken");

    property p_enq_clears;
        @(posedge ref_clk) disable iff (sys_rst)
        rx_take && is_enq |=> rx_level == RXLW'(1) && cmd_data == CHR_ENQ;
    endproperty
    a_enq_clears: assert property (p_enq_clears) else $error("buffer not cleared on start");

    property p_eot_clears;
        @(posedge ref_clk) disable iff (sys_rst)
        rx_take && is_eot |=> rx_level == '0 && !cmd_valid;
    endproperty
    a_eot_clears: assert property (p_eot_clears) else $error("buffer not cleared");

    property p_frame_open;
        @(posedge ref_clk) disable iff (sys_rst)
        r_reg.st == FR_IDLE && chg_valid |=> r_reg.st == FR_STX ##0 (!push || push_byte == CHR_STX);
    endproperty
    a_frame_open: assert property (p_frame_open) else $error("frame start wrong");

    property p_count_limit;
        @(posedge ref_clk) disable iff (sys_rst)
        r_reg.st == FR_CNT |-> r_reg.cnt != 8'h00 && r_reg.cnt <= limit;
    endproperty
    a_count_limit: assert property (p_count_limit) else $error("word count beyond limit");
endmodule // serial_flow_control_event_tx

// File: flow_event_pkg.sv
// constants shared by the serial flow control and event framing design
package flow_event_pkg;
    localparam logic [7:0] CHR_STX = 8'h02;
    localparam logic [7:0] CHR_ETX = 8'h03;
    localparam logic [7:0] CHR_EOT = 8'h04;
    localparam logic [7:0] CHR_ENQ = 8'h05;
    localparam logic [7:0] CHR_CR = 8'h0D;
    localparam logic [7:0] CHR_XON = 8'h11;
    localparam logic [7:0] CHR_XOFF = 8'h13;
    localparam logic [7:0] CHR_EVENT = 8'h45;
    localparam logic [7:0] CHR_ZERO = 8'h30;
    localparam logic [7:0] CHR_ALPHA = 8'h37;
    localparam logic [3:0] NIB_TEN = 4'hA;

    localparam int HOLD_BYTES = 1023;
    localparam int HOLD_AW = 10;
    localparam int RXQ_DEPTH = 8;

    localparam int APB_AW = 12;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;

    localparam int CTRL_CHK_BIT = 0;
    localparam int CTRL_SHORT_BIT = 1;
    localparam int CTRL_MAXW_LSB = 8;
    localparam logic CTRL_CHK_RST = 1'b0;
    localparam logic CTRL_SHORT_RST = 1'b0;
    localparam logic [7:0] CTRL_MAXW_RST = 8'h01;

    localparam int STAT_HALT_BIT = 0;
    localparam int STAT_STALL_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_RXLVL_LSB = 4;
    localparam int STAT_QCNT_LSB = 16;

    typedef enum logic [3:0] {
        FR_IDLE = 4'h0,
        FR_STX = 4'h1,
        FR_TAG = 4'h3,
        FR_ADDR = 4'h2,
        FR_CNT = 4'h6,
        FR_FETCH = 4'h7,
        FR_DATA = 4'h5,
        FR_ETX = 4'h4,
        FR_BCC = 4'hC,
        FR_CR = 4'hD
    } frame_state_e;
endpackage

// File: host_link_model.sv
// host side model: serial byte sink with optional stalling, plus data memory contents
`timescale 1ns/1ps

module host_link_model #(
    parameter logic [15:0] MEM_KEY = 16'hC3A5
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    output logic got,
    output logic [7:0] got_byte,
    input wire logic [15:0] data_memory_addr,
    output logic [15:0] data_memory_data
);
    // contents depend on the address so a wrong fetch address shows up in the data field
    assign data_memory_data = data_memory_addr ^ MEM_KEY;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_ready <= 1'b0;
            got <= 1'b0;
            got_byte <= 8'h00;
        end else begin
            // a slow host takes a byte at most every other cycle
            tx_ready <= slow ? ~tx_ready : 1'b1;
            // every accepted byte is reported in arrival order, the bench compares frames in that order
            got <= tx_valid & tx_ready;
            got_byte <= tx_data;
        end
    end
endmodule // host_link_model

// File: test_serial_flow_control_event_tx.sv
// self-checking bench for the serial flow control and event framing block
`timescale 1ns/1ps

module test_serial_flow_control_event_tx;
    import flow_event_pkg::*;
    localparam int HOLD_T = 16;
    localparam logic [15:0] KEY = 16'hC3A5;
    logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic rx_valid, rx_ready, cmd_valid, cmd_ready, tx_valid, tx_ready;
    logic [7:0] rx_data, cmd_data, tx_data, chg_words, got_byte;
    logic chg_valid, chg_ready, op_stall, slow, got;
    logic [15:0] chg_addr, data_memory_addr, data_memory_data;
    logic [3:0] rdy;
    logic [7:0] got_q[$];
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int samples_checked = 0;

    serial_flow_control_event_tx #(.HOLD_MAX(HOLD_T)) i_serial_flow_control_event_tx (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .chg_valid(chg_valid),
        .chg_ready(chg_ready), .chg_addr(chg_addr), .chg_words(chg_words),
        .data_memory_addr(data_memory_addr), .data_memory_data(data_memory_data),
        .op_stall(op_stall));

    host_link_model #(.MEM_KEY(KEY)) i_host_link_model (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .got(got), .got_byte(got_byte),
        .data_memory_addr(data_memory_addr), .data_memory_data(data_memory_data));

    assign rdy = {op_stall, pready, chg_ready, rx_ready};

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (got === 1'b1) got_q.push_back(got_byte);
    end

    task automatic print_verdict();
        if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] act, input logic [31:0] exp);
        samples_checked++;
        if (act !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, act, exp);
        end
    endtask

    task automatic bail(input int n);
        if (n > 400) begin
            num_errors++;
            print_verdict();
        end
    endtask

    task automatic await(input int w);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            bail(n);
        end while (rdy[w] !== 1'b1);
    endtask

    task automatic wait_bytes(input int k);
        int n;
        n = 0;
        while (got_q.size() < k) begin
            @(posedge ref_clk);
            n++;
            bail(n);
        end
    endtask

    task automatic reg_op(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d,
                          input logic [31:0] exp, input logic err_exp);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        await(2);
        if (!wr) cmp(prdata, exp);
        cmp(32'(pslverr), 32'(err_exp));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set_ctrl(input logic chk, input logic shrt, input logic [7:0] lim);
        reg_op(1'b1, OFS_CTRL, {16'h0000, lim, 6'h00, shrt, chk}, 32'h0000_0000, 1'b0);
    endtask

    // the host sends single bytes only, it never has a reply outstanding here
    task automatic send_rx(input logic [7:0] b);
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_data <= b;
        await(0);
        rx_valid <= 1'b0;
    endtask

    task automatic change(input logic [15:0] a, input logic [7:0] w);
        @(posedge ref_clk);
        chg_valid <= 1'b1;
        chg_addr <= a;
        chg_words <= w;
        await(1);
        chg_valid <= 1'b0;
    endtask

    function automatic logic [7:0] hexc(input logic [3:0] v);
        return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
    endfunction

    task automatic put_hex(input logic [15:0] v, input int nib);
        for (int i = nib - 1; i >= 0; i--) exp_q.push_back(hexc(v[i*4 +: 4]));
    endtask

    task automatic build(input logic [15:0] a, input int words, input int lim,
                         input logic chk, input logic shrt);
        int n, s;
        logic [7:0] x;
        if (lim == 0) lim = 1;
        while (words > 0) begin
            n = (words < lim) ? words : lim;
            s = exp_q.size();
            exp_q.push_back(CHR_STX);
            exp_q.push_back(CHR_EVENT);
            put_hex(a, 4);
            put_hex(16'(n), 2);
            for (int i = 0; i < n; i++) put_hex((a + 16'(i)) ^ KEY, 4);
            if (chk && !shrt) exp_q.push_back(CHR_ETX);
            x = 8'h00;
            for (int i = s; i < exp_q.size(); i++) x ^= exp_q[i];
            if (chk) put_hex({8'h00, x}, 2);
            exp_q.push_back(CHR_CR);
            a += 16'(n);
            words -= n;
        end
    endtask

    task automatic check_frames();
        wait_bytes(exp_q.size());
        // idle time lets any stray reply byte show up in the count
        repeat (20) @(posedge ref_clk);
        cmp(32'(got_q.size()), 32'(exp_q.size()));
        foreach (exp_q[i]) cmp(32'(got_q[i]), 32'(exp_q[i]));
        got_q.delete();
        exp_q.delete();
    endtask

    task automatic t_regs();
        reg_op(1'b0, OFS_CTRL, 32'h0000_0000, 32'h0000_0100, 1'b0);
        reg_op(1'b0, OFS_STATUS, 32'h0000_0000, 32'h0000_0000, 1'b0);
        reg_op(1'b0, 12'h008, 32'h0000_0000, 32'h0000_0000, 1'b1);
        reg_op(1'b1, OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
        set_ctrl(1'b1, 1'b1, 8'h02);
        reg_op(1'b0, OFS_CTRL, 32'h0000_0000, 32'h0000_0203, 1'b0);
    endtask

    task automatic t_frames();
        bit [1:0] opt [5] = '{2'b00, 2'b01, 2'b11, 2'b00, 2'b01}; // short, checksum
        int lim [5] = '{1, 1, 2, 0, 2};
        int wds [5] = '{1, 1, 2, 3, 3};
        for (int k = 0; k < 5; k++) begin
            slow <= k[0];
            set_ctrl(opt[k][0], opt[k][1], 8'(lim[k]));
            build(16'hA5F0 + 16'(k), wds[k], lim[k], opt[k][0], opt[k][1]);
            change(16'hA5F0 + 16'(k), 8'(wds[k]));
            check_frames();
        end
        slow <= 1'b0;
    endtask

    task automatic t_clear();
        for (int i = 0; i < 8; i++) send_rx(8'h41 + 8'(i));
        reg_op(1'b0, OFS_STATUS, 32'h0000_0000, 32'h0000_0080, 1'b0);
        // a ninth plain byte waits until the parser frees a slot
        rx_valid <= 1'b1;
        rx_data <= 8'h49;
        @(posedge ref_clk);
        cmp(32'(rx_ready), 32'h0000_0000);
        cmd_ready <= 1'b1;
        @(posedge ref_clk);
        cmd_ready <= 1'b0;
        await(0);
        rx_valid <= 1'b0;
        send_rx(CHR_EOT);
        @(posedge ref_clk);
        cmp(32'(cmd_valid), 32'h0000_0000);
        reg_op(1'b0, OFS_STATUS, 32'h0000_0000, 32'h0000_0000, 1'b0);
        cmp(32'(got_q.size()), 32'h0000_0000);
    endtask

    task automatic t_enq();
        send_rx(CHR_XOFF);
        reg_op(1'b0, OFS_STATUS, 32'h0000_0000, 32'h0000_0001, 1'b0);
        send_rx(8'h41);
        send_rx(8'h42);
        set_ctrl(1'b1, 1'b0, 8'h01);
        build(16'h1234, 1, 1, 1'b1, 1'b0);
        change(16'h1234, 8'h01);
        repeat (40) @(posedge ref_clk);
        cmp(32'(got_q.size()), 32'h0000_0000);
        // sixteen bytes fill the held queue exactly, which is no overflow
        reg_op(1'b0, OFS_STATUS, 32'h0000_0000, 32'h0010_0021, 1'b0);
        send_rx(CHR_ENQ);
        @(posedge ref_clk);
        cmp({23'h000000, cmd_valid, cmd_data}, {23'h000000, 1'b1, CHR_ENQ});
        check_frames();
        reg_op(1'b0, OFS_STATUS, 32'h0000_0000, 32'h0000_0010, 1'b0);
        cmd_ready <= 1'b1;
        @(posedge ref_clk);
        cmd_ready <= 1'b0;
        @(posedge ref_clk);
        cmp(32'(cmd_valid), 32'h0000_0000);
    endtask

    task automatic t_mid();
        int seen;
        slow <= 1'b1;
        set_ctrl(1'b1, 1'b0, 8'h04);
        build(16'hBEEF, 4, 4, 1'b1, 1'b0);
        change(16'hBEEF, 8'h04);
        wait_bytes(3);
        send_rx(CHR_XOFF);
        seen = got_q.size();
        await(3);
        reg_op(1'b0, OFS_STATUS, 32'h0000_0000, 32'h0010_0007, 1'b0);
        repeat (30) @(posedge ref_clk);
        cmp(32'(got_q.size() - seen <= 15), 32'h0000_0001);
        send_rx(CHR_XON);
        check_frames();
        cmp(32'(op_stall), 32'h0000_0000);
        slow <= 1'b0;
    endtask

    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0000_0000;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        cmd_ready = 1'b0;
        chg_valid = 1'b0;
        chg_addr = 16'h0000;
        chg_words = 8'h00;
        slow = 1'b0;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_frames();
        t_clear();
        t_enq();
        t_mid();
        print_verdict();
    end
endmodule // test_serial_flow_control_event_tx
